// [msxi_exec.sv]
// Purpose: Sequencer and datapath for nibble swap, skips, table reads and XOR
// Assumes: Program ROM and data memory answer in the same clock as the read strobe
// Notes: One pass through the execute state is one instruction cycle
//
// Notes on behaviour
// - Nibble swap puts the data byte's high nibble in accumulator bits 3..0 and low in 7..4, no flags, no memory write.
// - Skip-if-zero tests the data byte and on zero discards the prefetch with a dummy cycle, flags kept.
// - Move-and-skip copies the data byte to the accumulator and skips with a dummy cycle when it is zero.
// - Skip-if-bit-clear skips with a dummy cycle when the selected bit of the data byte is 0.
// - Current-page table read writes the low byte of the word at current page and table pointer to memory, the high part to the latch.
// - Last-page table read does the same from the final program page.
// - XOR to accumulator stores accumulator XOR data byte in the accumulator and updates only the zero flag.
// - XOR to memory stores accumulator XOR data byte back in the data byte and updates only the zero flag.
// - XOR immediate stores accumulator XOR the immediate in the accumulator and updates only the zero flag.

`timescale 1ns/10ps
`default_nettype none

module msxi_exec (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Program ROM
  output logic [10:0] o_rom_addr,
  output logic o_rom_rd,
  input wire logic [13:0] i_rom_data,
  // Data memory
  output logic [6:0] o_ram_addr,
  output logic o_ram_rd,
  input wire logic [7:0] i_ram_rdata,
  output logic o_ram_we,
  output logic [7:0] o_ram_wdata,
  // Core registers
  input wire logic [7:0] i_table_pointer,
  output logic [7:0] o_acc,
  output logic o_zero_flag,
  output logic [5:0] o_table_high_latch,
  // Status
  output logic [10:0] o_pc,
  output logic o_instr_done,
  output logic o_skip
);

  // ----------------------------------------------------------------
  // Helpers and decode
  // ----------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] b);
    is_zero = (b == 8'h00);
  endfunction

  msxi_pkg::msxi_state_t st_q;
  logic [13:0] ir_q;
  logic [13:0] pre_q;
  logic [2:0] page_q;
  logic d_swap, d_skz, d_mvskz, d_skbit, d_trdc, d_trdl, d_xora, d_exclusive_or_to_memory, d_xori;
  logic [6:0] d_addr;
  logic [2:0] d_bitsel;
  logic [7:0] d_imm;
  logic take_skip;
  logic [7:0] xor_mem;

  msxi_decode u_decode (
    .i_word(ir_q),
    .o_swap(d_swap),
    .o_skz(d_skz),
    .o_mvskz(d_mvskz),
    .o_skbit(d_skbit),
    .o_trdc(d_trdc),
    .o_trdl(d_trdl),
    .o_xora(d_xora),
    .o_exclusive_or_to_memory(d_exclusive_or_to_memory),
    .o_xori(d_xori),
    .o_addr(d_addr),
    .o_bitsel(d_bitsel),
    .o_imm(d_imm)
  );

  assign xor_mem = o_acc ^ i_ram_rdata;
  // Memory read data is valid only in the execute state
  assign take_skip = ((d_skz || d_mvskz) && is_zero(i_ram_rdata))
                     || (d_skbit && !i_ram_rdata[d_bitsel]);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= msxi_pkg::ST_FETCH;
    end else begin
      unique case (st_q)
        msxi_pkg::ST_FETCH: st_q <= msxi_pkg::ST_LOAD;
        msxi_pkg::ST_LOAD: st_q <= msxi_pkg::ST_OPER;
        msxi_pkg::ST_OPER: st_q <= msxi_pkg::ST_EXEC;
        msxi_pkg::ST_EXEC: begin
          if (d_trdc || d_trdl) begin
            st_q <= msxi_pkg::ST_TABLE;
          end else if (take_skip) begin
            st_q <= msxi_pkg::ST_DUMMY;
          end else begin
            st_q <= msxi_pkg::ST_OPER;
          end
        end
        msxi_pkg::ST_TABLE: st_q <= msxi_pkg::ST_OPER;
        msxi_pkg::ST_DUMMY: st_q <= msxi_pkg::ST_LOAD;
        default: st_q <= msxi_pkg::ST_FETCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program counter, instruction and prefetch registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc <= msxi_pkg::PC_RST;
      ir_q <= msxi_pkg::IW_RST;
      pre_q <= msxi_pkg::IW_RST;
      page_q <= '0;
    end else begin
      if (st_q == msxi_pkg::ST_LOAD) begin
        ir_q <= i_rom_data;
        page_q <= o_pc[10:8];
        o_pc <= o_pc + 11'h001;
      end
      if (st_q == msxi_pkg::ST_EXEC) begin
        pre_q <= i_rom_data;
        if (!(d_trdc || d_trdl) && !take_skip) begin
          ir_q <= i_rom_data;
          page_q <= o_pc[10:8];
          o_pc <= o_pc + 11'h001;
        end
        // Squashed word is passed over, never executed
        if (!(d_trdc || d_trdl) && take_skip) begin
          o_pc <= o_pc + 11'h001;
        end
      end
      if (st_q == msxi_pkg::ST_TABLE) begin
        ir_q <= pre_q;
        page_q <= o_pc[10:8];
        o_pc <= o_pc + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program ROM port
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rom_addr <= msxi_pkg::PC_RST;
      o_rom_rd <= 1'b0;
    end else begin
      o_rom_rd <= 1'b0;
      // The dummy cycle refetches, so a skip costs one cycle and no stall
      if (st_q == msxi_pkg::ST_FETCH || st_q == msxi_pkg::ST_OPER
          || st_q == msxi_pkg::ST_DUMMY) begin
        o_rom_addr <= o_pc;
        o_rom_rd <= 1'b1;
      end else if (st_q == msxi_pkg::ST_EXEC && d_trdc) begin
        o_rom_addr <= {page_q, i_table_pointer};
        o_rom_rd <= 1'b1;
      end else if (st_q == msxi_pkg::ST_EXEC && d_trdl) begin
        o_rom_addr <= {msxi_pkg::LAST_PAGE, i_table_pointer};
        o_rom_rd <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ram_addr <= '0;
      o_ram_rd <= 1'b0;
      o_ram_we <= 1'b0;
      o_ram_wdata <= '0;
    end else begin
      o_ram_rd <= (st_q == msxi_pkg::ST_OPER);
      o_ram_we <= 1'b0;
      if (st_q == msxi_pkg::ST_OPER) begin
        o_ram_addr <= d_addr;
      end
      if (st_q == msxi_pkg::ST_EXEC && d_exclusive_or_to_memory) begin
        o_ram_we <= 1'b1;
        o_ram_wdata <= xor_mem;
      end
      if (st_q == msxi_pkg::ST_TABLE) begin
        o_ram_we <= 1'b1;
        o_ram_wdata <= i_rom_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, zero flag and table-high latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= msxi_pkg::ACC_RST;
      o_zero_flag <= 1'b0;
    end else if (st_q == msxi_pkg::ST_EXEC) begin
      if (d_swap) begin
        o_acc <= {i_ram_rdata[3:0], i_ram_rdata[7:4]};
      end else if (d_mvskz) begin
        o_acc <= i_ram_rdata;
      end else if (d_xora) begin
        o_acc <= xor_mem;
        o_zero_flag <= is_zero(xor_mem);
      end else if (d_exclusive_or_to_memory) begin
        o_zero_flag <= is_zero(xor_mem);
      end else if (d_xori) begin
        o_acc <= o_acc ^ d_imm;
        o_zero_flag <= is_zero(o_acc ^ d_imm);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_table_high_latch <= msxi_pkg::TH_RST;
    end else if (st_q == msxi_pkg::ST_TABLE) begin
      o_table_high_latch <= i_rom_data[13:8];
    end
  end

  // ----------------------------------------------------------------
  // Status pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_instr_done <= 1'b0;
      o_skip <= 1'b0;
    end else begin
      o_instr_done <= (st_q == msxi_pkg::ST_EXEC && !(d_trdc || d_trdl))
                      || st_q == msxi_pkg::ST_TABLE;
      o_skip <= (st_q == msxi_pkg::ST_DUMMY);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic in_exec;
  assign in_exec = (st_q == msxi_pkg::ST_EXEC);

  sequence dummy_then_refetch;
    st_q == msxi_pkg::ST_DUMMY ##1 (st_q == msxi_pkg::ST_LOAD && o_rom_rd);
  endsequence

  sequence table_write_back;
    o_rom_rd ##1 (o_ram_we && o_ram_wdata == $past(i_rom_data[7:0])
                  && o_table_high_latch == $past(i_rom_data[13:8]));
  endsequence

  swap_nibbles_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_swap |=> o_acc == {$past(i_ram_rdata[3:0]), $past(i_ram_rdata[7:4])}
      && $stable(o_zero_flag) && !o_ram_we)
    else $error("nibble swap result wrong");

  skip_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_skz |=> (is_zero($past(i_ram_rdata)) ? st_q == msxi_pkg::ST_DUMMY
      : st_q == msxi_pkg::ST_OPER) && $stable(o_zero_flag))
    else $error("skip if zero timing wrong");

  move_skip_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_mvskz && is_zero(i_ram_rdata) |=> o_acc == 8'h00 ##0 dummy_then_refetch)
    else $error("move and skip wrong");

  skip_bit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_skbit |=> (st_q == msxi_pkg::ST_DUMMY) == !$past(i_ram_rdata[d_bitsel]))
    else $error("bit skip decision wrong");

  table_cur_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_trdc |=> o_rom_addr == {$past(page_q), $past(i_table_pointer)}
      ##0 table_write_back)
    else $error("current page table read wrong");

  table_last_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_trdl |=> o_rom_addr[10:8] == msxi_pkg::LAST_PAGE ##0 table_write_back)
    else $error("last page table read wrong");

  xor_acc_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_xora |=> o_acc == ($past(o_acc) ^ $past(i_ram_rdata))
      && o_zero_flag == (o_acc == 8'h00))
    else $error("xor to accumulator wrong");

  xor_mem_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_exclusive_or_to_memory |=> o_ram_we && o_ram_wdata == ($past(o_acc) ^ $past(i_ram_rdata))
      && $stable(o_acc) && o_zero_flag == (o_ram_wdata == 8'h00))
    else $error("xor to memory wrong");

  xor_imm_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && d_xori |=> o_acc == ($past(o_acc) ^ $past(d_imm))
      && o_zero_flag == (o_acc == 8'h00))
    else $error("xor immediate wrong");

  prefetch_use_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_exec && !take_skip && !d_trdc && !d_trdl |=> ir_q == $past(i_rom_data)
      && st_q == msxi_pkg::ST_OPER)
    else $error("prefetched word not used");

endmodule

`default_nettype wire

// [msxi_pkg.sv]
// Purpose: Constants and types for the skip, table-read and XOR execution unit
// Assumes: 14-bit program words, 11-bit program counter, 7-bit data memory address
// Notes: Opcode encodings are local to this unit

package msxi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 11;
  localparam int IW_W = 14;
  localparam int RA_W = 7;
  localparam int DW_W = 8;
  localparam int TH_W = 6;
  localparam int PAGE_W = 3;

  // ----------------------------------------------------------------
  // Instruction field positions
  // ----------------------------------------------------------------
  localparam int OP7_LSB = 7;
  localparam int OP6_LSB = 8;
  localparam int OP4_LSB = 10;
  localparam int BIT_LSB = 7;

  // ----------------------------------------------------------------
  // Opcode encodings
  // ----------------------------------------------------------------
  localparam logic [6:0] OP_SWAP_ACC = 7'h11;
  localparam logic [6:0] OP_SKIP_ZERO = 7'h12;
  localparam logic [6:0] OP_MOVE_SKIP = 7'h13;
  localparam logic [6:0] OP_TRD_CUR = 7'h14;
  localparam logic [6:0] OP_TRD_LAST = 7'h15;
  localparam logic [6:0] OP_XOR_ACC = 7'h16;
  localparam logic [6:0] OP_XOR_MEM = 7'h17;
  localparam logic [5:0] OP_XOR_IMM = 6'h3c;
  localparam logic [3:0] OP_SKIP_BIT = 4'h3;

  // ----------------------------------------------------------------
  // Reset values and fixed pages
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [DW_W-1:0] ACC_RST = 8'h00;
  localparam logic [TH_W-1:0] TH_RST = 6'h00;
  localparam logic [IW_W-1:0] IW_RST = 14'h0000;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_FETCH = 6'h01,
    ST_LOAD  = 6'h02,
    ST_OPER  = 6'h04,
    ST_EXEC  = 6'h08,
    ST_TABLE = 6'h10,
    ST_DUMMY = 6'h20
  } msxi_state_t;

endpackage

// [msxi_decode.sv]
// Purpose: Splits a program word into operation strobes and operand fields
// Assumes: Combinational, driven from the instruction register
// Notes: Words outside this group raise no strobe and execute as a no-operation

`timescale 1ns/10ps
`default_nettype none

module msxi_decode (
  // Instruction word
  input wire logic [13:0] i_word,
  // Operation strobes
  output logic o_swap,
  output logic o_skz,
  output logic o_mvskz,
  output logic o_skbit,
  output logic o_trdc,
  output logic o_trdl,
  output logic o_xora,
  output logic o_exclusive_or_to_memory,
  output logic o_xori,
  // Operand fields
  output logic [6:0] o_addr,
  output logic [2:0] o_bitsel,
  output logic [7:0] o_imm
);

  logic [6:0] op7;
  assign op7 = i_word[13:msxi_pkg::OP7_LSB];

  assign o_swap = (op7 == msxi_pkg::OP_SWAP_ACC);
  assign o_skz = (op7 == msxi_pkg::OP_SKIP_ZERO);
  assign o_mvskz = (op7 == msxi_pkg::OP_MOVE_SKIP);
  assign o_trdc = (op7 == msxi_pkg::OP_TRD_CUR);
  assign o_trdl = (op7 == msxi_pkg::OP_TRD_LAST);
  assign o_xora = (op7 == msxi_pkg::OP_XOR_ACC);
  assign o_exclusive_or_to_memory = (op7 == msxi_pkg::OP_XOR_MEM);
  assign o_xori = (i_word[13:msxi_pkg::OP6_LSB] == msxi_pkg::OP_XOR_IMM);
  assign o_skbit = (i_word[13:msxi_pkg::OP4_LSB] == msxi_pkg::OP_SKIP_BIT);

  assign o_addr = i_word[6:0];
  assign o_bitsel = i_word[msxi_pkg::BIT_LSB+2:msxi_pkg::BIT_LSB];
  assign o_imm = i_word[7:0];

endmodule

`default_nettype wire

// [msxi_mem_model.sv]
// Purpose: Program ROM and data memory seen from the execution unit
// Assumes: Both answer while the read strobe stands, for the unit to sample at the next edge
// Notes: ROM lines show the inverse of the last word when no read is answered

`timescale 1ns/10ps
`default_nettype none

module msxi_mem_model (
  // Clock
  input wire logic i_core_clk,
  // Program ROM
  input wire logic [10:0] i_rom_addr,
  input wire logic i_rom_rd,
  output logic [13:0] o_rom_data,
  // Data memory
  input wire logic [6:0] i_ram_addr,
  input wire logic i_ram_rd,
  output logic [7:0] o_ram_rdata,
  input wire logic i_ram_we,
  input wire logic [7:0] i_ram_wdata
);
  logic [13:0] rom [0:2047];
  logic [7:0] ram [0:127];
  logic [13:0] rom_last_q;
  logic [7:0] ram_last_q;

  // ----------------------------------------------------------------
  // Answers
  // ----------------------------------------------------------------
  // Idle lines show the inverse of the last answer so a stray sample cannot pass by luck
  assign o_rom_data = i_rom_rd ? rom[i_rom_addr] : ~rom_last_q;
  assign o_ram_rdata = i_ram_rd ? ram[i_ram_addr] : ~ram_last_q;

  always @(posedge i_core_clk) begin
    if (i_rom_rd) begin
      rom_last_q <= rom[i_rom_addr];
    end
  end

  // Writes land at the edge, so a read in the next cycle sees the new byte
  always @(posedge i_core_clk) begin
    if (i_ram_we) begin
      ram[i_ram_addr] <= i_ram_wdata;
    end
    if (i_ram_rd) begin
      ram_last_q <= ram[i_ram_addr];
    end
  end
endmodule

`default_nettype wire

// [mcu_skip_table_xor_instr_tb.sv]
// Purpose: Self-checking bench for the skip, table-read and XOR execution unit
// Assumes: Programs are preloaded into the memory model while reset is held
// Notes: Results are judged once the program counter has run past each program

`timescale 1ns/10ps
`default_nettype none

module mcu_skip_table_xor_instr_tb;
  logic i_core_clk, i_rst_n;
  logic [10:0] rom_addr, o_pc;
  logic rom_rd, ram_rd, ram_we, o_zero_flag, o_instr_done, o_skip;
  logic [13:0] rom_data;
  logic [6:0] ram_addr;
  logic [7:0] ram_rdata, ram_wdata, tptr, o_acc;
  logic [5:0] o_table_high_latch;
  int error_cnt, compares, skip_cnt, done_cnt, cyc_cnt;

  msxi_exec i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_rom_addr(rom_addr),
    .o_rom_rd(rom_rd), .i_rom_data(rom_data), .o_ram_addr(ram_addr), .o_ram_rd(ram_rd),
    .i_ram_rdata(ram_rdata), .o_ram_we(ram_we), .o_ram_wdata(ram_wdata),
    .i_table_pointer(tptr), .o_acc(o_acc), .o_zero_flag(o_zero_flag),
    .o_table_high_latch(o_table_high_latch), .o_pc(o_pc), .o_instr_done(o_instr_done),
    .o_skip(o_skip));

  msxi_mem_model i_mem (.i_core_clk(i_core_clk), .i_rom_addr(rom_addr), .i_rom_rd(rom_rd),
    .o_rom_data(rom_data), .i_ram_addr(ram_addr), .i_ram_rd(ram_rd),
    .o_ram_rdata(ram_rdata), .i_ram_we(ram_we), .i_ram_wdata(ram_wdata));

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc_cnt++;
    if (o_skip === 1'b1) begin
      skip_cnt++;
    end
    if (o_instr_done === 1'b1) begin
      done_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] w7(input logic [6:0] op, input logic [6:0] a);
    return {op, a};
  endfunction

  function automatic logic [13:0] xi(input logic [7:0] v);
    return {msxi_pkg::OP_XOR_IMM, v};
  endfunction

  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Memories are cleared so stray words decode as no-operations
  task automatic rst_on();
    @(posedge i_core_clk);
    #1 i_rst_n = 1'b0;
    for (int i = 0; i < 2048; i++) i_mem.rom[i] = 14'h0000;
    for (int i = 0; i < 128; i++) i_mem.ram[i] = 8'h00;
    skip_cnt = 0;
    done_cnt = 0;
  endtask

  task automatic rst_off();
    repeat (5) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    cyc_cnt = 0;
  endtask

  // Instruction k is finished once the counter reaches k+2; targets leave room for write-back
  task automatic run_to(input int tgt);
    int n;
    n = 0;
    while (o_pc < 11'(tgt) && n < 400) begin
      @(posedge i_core_clk);
      #2 n++;
    end
    if (o_pc < 11'(tgt)) begin
      error_cnt++;
      $display("[ERR] %0t program counter stuck", $time);
      summarize();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_swap();
    rst_on();
    i_mem.ram[5] = 8'h3c;
    i_mem.rom[0] = xi(8'h00);
    i_mem.rom[1] = w7(msxi_pkg::OP_SWAP_ACC, 7'd5);
    #10 chk({3'h0, o_pc}, 14'h0000, "reset pc");
    chk({6'h00, o_acc}, 14'h0000, "reset acc");
    chk({8'h00, o_table_high_latch}, 14'h0000, "reset latch");
    rst_off();
    run_to(5);
    chk({6'h00, o_acc}, 14'h00c3, "swap acc");
    chk({13'h0, o_zero_flag}, 14'h0001, "swap zero kept");
    chk({6'h00, i_mem.ram[5]}, 14'h003c, "swap mem kept");
    $display("test swap done");
  endtask

  task automatic t_xor();
    rst_on();
    i_mem.ram[3] = 8'ha5;
    i_mem.ram[4] = 8'h0f;
    i_mem.rom[0] = xi(8'ha5);
    i_mem.rom[1] = w7(msxi_pkg::OP_XOR_ACC, 7'd3);
    i_mem.rom[2] = xi(8'h0f);
    i_mem.rom[3] = w7(msxi_pkg::OP_XOR_MEM, 7'd4);
    rst_off();
    run_to(7);
    chk({6'h00, o_acc}, 14'h000f, "xor acc");
    chk({6'h00, i_mem.ram[3]}, 14'h00a5, "xor src kept");
    chk({6'h00, i_mem.ram[4]}, 14'h0000, "xor mem");
    chk({13'h0, o_zero_flag}, 14'h0001, "xor zero");
    $display("test xor done");
  endtask

  task automatic t_skip();
    logic [13:0] p [0:12];
    rst_on();
    i_mem.ram[2] = 8'h80;
    p = '{w7(msxi_pkg::OP_SKIP_ZERO, 7'd1), xi(8'hff), xi(8'h01),
      w7(msxi_pkg::OP_SKIP_ZERO, 7'd2), xi(8'h02), w7(msxi_pkg::OP_MOVE_SKIP, 7'd1),
      xi(8'h40), xi(8'h10), {msxi_pkg::OP_SKIP_BIT, 3'd7, 7'd2}, xi(8'h20),
      {msxi_pkg::OP_SKIP_BIT, 3'd6, 7'd2}, xi(8'h80), xi(8'h01)};
    for (int i = 0; i < 13; i++) i_mem.rom[i] = p[i];
    rst_off();
    run_to(16);
    chk({6'h00, o_acc}, 14'h0031, "skip acc");
    chk(14'(skip_cnt), 14'h0003, "skip count");
    // Nine plain cycles and three two-cycle skips at two clocks a cycle, after the first fetch
    chk(14'(cyc_cnt), 14'h0020, "skip clocks");
    chk(14'(done_cnt), 14'h000b, "done pulses");
    chk({13'h0, o_instr_done}, 14'h0001, "last done");
    chk({13'h0, o_zero_flag}, 14'h0000, "skip zero");
    chk({6'h00, i_mem.ram[1]}, 14'h0000, "skip mem kept");
    $display("test skip done");
  endtask

  task automatic t_table();
    rst_on();
    tptr = 8'hf0;
    i_mem.rom[11'h0f0] = 14'h2a5b;
    i_mem.rom[11'h7f0] = 14'h1c3d;
    i_mem.rom[0] = xi(8'h00);
    i_mem.rom[1] = w7(msxi_pkg::OP_TRD_LAST, 7'd9);
    i_mem.rom[2] = w7(msxi_pkg::OP_TRD_CUR, 7'd8);
    rst_off();
    run_to(3);
    chk({8'h00, o_table_high_latch}, 14'h001c, "last page high");
    run_to(6);
    chk({6'h00, i_mem.ram[9]}, 14'h003d, "last page low");
    run_to(7);
    chk({6'h00, i_mem.ram[8]}, 14'h005b, "cur page low");
    chk({8'h00, o_table_high_latch}, 14'h002a, "cur page high");
    chk({13'h0, o_zero_flag}, 14'h0001, "table zero kept");
    $display("test table done");
  endtask

  initial begin
    i_rst_n = 1'b0;
    tptr = 8'h00;
    error_cnt = 0;
    compares = 0;
    t_swap();
    t_xor();
    t_skip();
    t_table();
    summarize();
  end
endmodule

`default_nettype wire
